// [rtl/ntsp_fifo.sv]
// Request FIFO with valid and ready on both sides.
module ntsp_fifo #(
  parameter int Width = 64,
  parameter int Depth = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  ntsp_req_if.src out
);
  localparam int PtrW = $clog2(Depth);
  // Storage in flip-flops, addressed by index.
  logic [Width-1:0] mem [Depth];
  logic [PtrW-1:0] wrPtr_q;
  logic [PtrW-1:0] rdPtr_q;
  // Count needs one extra bit to tell full from empty.
  logic [PtrW:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the count.
  assign inReady = (count_q != (PtrW+1)'(Depth));
  assign out.valid = (count_q != '0);
  assign out.data = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = out.valid && out.ready;

  // Write port of the storage.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= (wrPtr_q == PtrW'(Depth-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= (rdPtr_q == PtrW'(Depth-1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // The count never passes the depth.
  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    count_q <= (PtrW+1)'(Depth))
    else $error("fifo count above depth");
endmodule : ntsp_fifo

// [rtl/ntsp_pkg.sv]
// Package with shared constants for the no-turnaround SRAM port.
package ntsp_pkg;
  // Default data width of the memory data bus.
  localparam int DataWidth = 32;
  // Default address width of the memory.
  localparam int AddrWidth = 18;
  // Default number of byte lanes.
  localparam int ByteLanes = 4;
  // Depth of the request buffer in front of the memory port.
  localparam int FifoDepth = 16;
  // Cycles from address edge to data phase for each memory variant.
  localparam int FlowLatency = 1;
  localparam int PipeLatency = 2;
  // Longest data-phase delay the pipeline must carry.
  localparam int MaxLatency = 2;
  // Reset values of the active-low memory controls.
  localparam logic RwLowReset = 1'b1;
  localparam logic AdvLoadReset = 1'b0;
endpackage : ntsp_pkg

// [rtl/ntsp_req_if.sv]
// Interface carrying requests from the buffer to the memory port logic.
interface ntsp_req_if #(
  parameter int Width = 64
);
  // Request is present.
  logic valid;
  // Port logic takes the request.
  logic ready;
  // Packed request word.
  logic [Width-1:0] data;
  // Buffer side drives valid and data.
  modport src (output valid, output data, input ready);
  // Port side drives ready.
  modport dst (input valid, input data, output ready);
endinterface : ntsp_req_if

// [rtl/ntsp_sram_port.sv]
// Top of the no-turnaround synchronous SRAM port.
// What this block does
// - Transfer every cycle, no turnaround dead cycle.
// - Shared data bus, driven only for writes.
// - Drive read/write, byte enables, advance/load.
// - Interleaved addresses keep their own data.
// - Pipelined memory adds one data cycle.
module ntsp_sram_port #(
  parameter int DataWidth = ntsp_pkg::DataWidth,
  parameter int AddrWidth = ntsp_pkg::AddrWidth,
  parameter int ByteLanes = ntsp_pkg::ByteLanes,
  parameter int FifoDepth = ntsp_pkg::FifoDepth
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pipelinedMode,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [AddrWidth-1:0] reqAddr,
  input wire logic [DataWidth-1:0] reqWrData,
  input wire logic [ByteLanes-1:0] reqByteEn,
  output logic rdValid,
  output logic [DataWidth-1:0] rdData,
  output logic [AddrWidth-1:0] memAddr,
  output logic readWriteLow,
  output logic [ByteLanes-1:0] byte_write_enable_low,
  output logic burst_advance_or_load,
  output logic [DataWidth-1:0] memDataOut,
  output logic memDataOe,
  input wire logic [DataWidth-1:0] memDataIn
);
  // Packed request: write flag, byte enables, address, data.
  localparam int ReqW = 1 + ByteLanes + AddrWidth + DataWidth;
  // Stage 0 is loaded on the edge that issues the address, so the stages must
  // reach one past the longest data-phase delay; a shorter pipe would put
  // write data on the bus in the very cycle that the address is presented.
  localparam int Lat = ntsp_pkg::MaxLatency + 1;

  ntsp_req_if #(.Width(ReqW)) req ();

  // Requests are buffered; the buffer's ready is the caller's back-pressure.
  ntsp_fifo #(
    .Width(ReqW),
    .Depth(FifoDepth)
  ) reqFifo (
    .clk(clk),
    .rst(rst),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqWrite, reqByteEn, reqAddr, reqWrData}),
    .out(req)
  );

  // The memory answers every cycle, so the port always takes a request.
  assign req.ready = 1'b1;

  // Fields of the request at the head of the buffer.
  logic hdWrite;
  logic [ByteLanes-1:0] hdByteEn;
  logic [AddrWidth-1:0] hdAddr;
  logic [DataWidth-1:0] hdData;
  assign {hdWrite, hdByteEn, hdAddr, hdData} = req.data;

  // Per-stage record of the data phase still owed to each address.
  logic [Lat-1:0] phValid_q;
  logic [Lat-1:0] phWrite_q;
  logic [DataWidth-1:0] phData_q [Lat];
  // Mode is sampled once per address so a change never splits a pair.
  logic [Lat-1:0] phPipe_q;

  // Address and control phase, one command per rising edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Reset leaves the memory seeing a harmless read with no byte enables.
      memAddr <= '0;
      readWriteLow <= ntsp_pkg::RwLowReset;
      byte_write_enable_low <= '1;
      burst_advance_or_load <= ntsp_pkg::AdvLoadReset;
    end
    else if (req.valid)
    begin
      // Load a fresh address; read and write may follow back to back.
      memAddr <= hdAddr;
      readWriteLow <= !hdWrite;
      byte_write_enable_low <= hdWrite ? ~hdByteEn : '1;
      burst_advance_or_load <= 1'b0;
    end
    else
    begin
      // Idle: a deselect-free hold as a read with no byte enables.
      readWriteLow <= 1'b1;
      byte_write_enable_low <= '1;
      burst_advance_or_load <= 1'b0;
    end
  end

  // Shift the owed data phases; stage i is loaded i edges after the address edge.
  // Data is copied whatever the command; only write stages ever reach the bus.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phValid_q <= '0;
      phWrite_q <= '0;
      phPipe_q <= '0;
      for (int i = 0; i < Lat; i++)
      begin
        phData_q[i] <= '0;
      end
    end
    else
    begin
      phValid_q <= {phValid_q[Lat-2:0], req.valid};
      phWrite_q <= {phWrite_q[Lat-2:0], req.valid && hdWrite};
      phPipe_q <= {phPipe_q[Lat-2:0], pipelinedMode};
      phData_q[0] <= hdData;
      for (int i = 1; i < Lat; i++)
      begin
        phData_q[i] <= phData_q[i-1];
      end
    end
  end

  // Pick the stage that is due now for each memory variant.
  logic dueValid;
  logic dueWrite;
  logic [DataWidth-1:0] dueData;
  always_comb
  begin
    // A flow-through phase falls in the cycle after the memory samples the address.
    dueValid = phValid_q[ntsp_pkg::FlowLatency] && !phPipe_q[ntsp_pkg::FlowLatency];
    dueWrite = phWrite_q[ntsp_pkg::FlowLatency];
    dueData = phData_q[ntsp_pkg::FlowLatency];
    if (phPipe_q[ntsp_pkg::PipeLatency] && phValid_q[ntsp_pkg::PipeLatency])
    begin
      // The pipelined part returns one cycle later.
      dueValid = 1'b1;
      dueWrite = phWrite_q[ntsp_pkg::PipeLatency];
      dueData = phData_q[ntsp_pkg::PipeLatency];
    end
  end

  // Data bus drive is combinational from the stage registers so the bus turns
  // each cycle with no gap; contention margin is left to pad timing.
  assign memDataOe = dueValid && dueWrite;
  assign memDataOut = dueData;

  // Read return, registered at the edge that ends the data phase.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdValid <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      // Only read phases return data; a write phase leaves rdData as it stands.
      rdValid <= dueValid && !dueWrite;
      if (dueValid && !dueWrite)
      begin
        rdData <= memDataIn;
      end
    end
  end

  // A flow-through write drives the bus in the cycle after its address is sampled.
  flow_write_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && hdWrite && !pipelinedMode) |=> ##1 memDataOe)
    else $error("flow-through write data missing");

  // A pipelined write drives the bus one cycle later still.
  pipe_write_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && hdWrite && pipelinedMode) |=> ##2 memDataOe)
    else $error("pipelined write data missing");

  // Bus is never driven in a flow-through read data phase.
  read_release_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !hdWrite && !pipelinedMode) |=> ##1 !memDataOe)
    else $error("bus driven during read");

  // Bus is never driven in a pipelined read data phase.
  pipe_release_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !hdWrite && pipelinedMode) |=> ##2 !memDataOe)
    else $error("bus driven during pipelined read");

  // A queued request goes out on the very next edge.
  every_cycle_a: assert property (@(posedge clk) disable iff (rst)
    req.valid |=> (readWriteLow == !$past(hdWrite)))
    else $error("request not issued");

  // Address issued matches the request taken.
  addr_pair_a: assert property (@(posedge clk) disable iff (rst)
    req.valid |=> memAddr == $past(hdAddr))
    else $error("address mismatch");

  // Byte enables are inactive on reads.
  byte_read_a: assert property (@(posedge clk) disable iff (rst)
    readWriteLow |-> byte_write_enable_low == '1)
    else $error("byte enable active on read");

  // A flow-through read returns data two edges after leaving the buffer.
  read_return_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !hdWrite && !pipelinedMode) |=> ##2 rdValid)
    else $error("read return late");

  // A pipelined read returns data one edge later than a flow-through one.
  pipe_return_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !hdWrite && pipelinedMode) |=> ##3 rdValid)
    else $error("pipelined read return late");

  // Flow-through written data follows its address unchanged.
  write_data_a: assert property (@(posedge clk) disable iff (rst)
    (req.valid && hdWrite && !pipelinedMode) |=> ##1 memDataOut == $past(hdData, 2))
    else $error("write data mismatch");
endmodule : ntsp_sram_port

// [verif/ntsp_sram_model.sv]
// Behavioural zero-turnaround synchronous memory that faces the port.
module ntsp_sram_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pipe,
  input wire logic [17:0] addr,
  input wire logic rwLow,
  input wire logic [3:0] beLow,
  input wire logic [31:0] dOut,
  output logic [31:0] dIn,
  output logic expOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stages hold write flag, address and byte enables.
  logic [8:0] cmd1;
  logic [8:0] cmd2;
  logic [8:0] act;
  logic [31:0] mem [16];
  logic [31:0] lastQ;
  // Pipelined parts answer one cycle after flow-through ones.
  assign act = pipe ? cmd2 : cmd1;
  // The port should drive only in write data cycles.
  assign expOe = act[8];
  // In a write data cycle the read input shows the inverse of its last value, so stale data never matches.
  assign dIn = act[8] ? ~lastQ : mem[act[7:4]];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  // Everything happens on the rising edge; a command may follow every cycle.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd1 <= 9'h000;
      cmd2 <= 9'h000;
    end
    else
    begin
      // Only lanes whose low-active enable is low are written.
      for (int b = 0; b < 4; b++)
        if (act[8] && !act[b]) mem[act[7:4]][8*b +: 8] <= dOut[8*b +: 8];
      cmd1 <= {~rwLow, addr[3:0], beLow};
      cmd2 <= cmd1;
      lastQ <= dIn;
    end
  end
endmodule // ntsp_sram_model

// [verif/testbench.sv]
// Self-checking bench for the no-turnaround memory port.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // One request row and the read data it should return.
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [31:0] d;
    logic [3:0] be;
    logic [31:0] e;
  } ntsp_row_t;
  // Reads and writes are mixed, with back-to-back pairs of each, so no turnaround gap can hide.
  localparam ntsp_row_t Rows [8] = '{
    '{1'b1, 4'h1, 32'h11111111, 4'hf, 32'h0}, '{1'b1, 4'h2, 32'h22222222, 4'hf, 32'h0},
    '{1'b0, 4'h1, 32'h0, 4'h0, 32'h11111111}, '{1'b1, 4'h1, 32'haaaaaaaa, 4'h5, 32'h0},
    '{1'b0, 4'h2, 32'h0, 4'h0, 32'h22222222}, '{1'b0, 4'h1, 32'h0, 4'h0, 32'h11aa11aa},
    '{1'b1, 4'h3, 32'h33333333, 4'hf, 32'h0}, '{1'b0, 4'h3, 32'h0, 4'h0, 32'h33333333}};
  logic clk, rst, pipelinedMode, reqValid, reqReady, reqWrite, rdValid;
  logic [17:0] reqAddr, memAddr;
  logic [31:0] reqWrData, rdData, memDataOut, memDataIn;
  logic [3:0] reqByteEn, byte_write_enable_low;
  logic readWriteLow, burst_advance_or_load, memDataOe, expOe;
  logic [31:0] expQ [$];
  int error_cnt = 0;
  int cmp_count = 0;
  ntsp_sram_port ntsp_sram_port_inst (.clk(clk), .rst(rst), .pipelinedMode(pipelinedMode),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWrData(reqWrData), .reqByteEn(reqByteEn), .rdValid(rdValid), .rdData(rdData),
    .memAddr(memAddr), .readWriteLow(readWriteLow),
    .byte_write_enable_low(byte_write_enable_low),
    .burst_advance_or_load(burst_advance_or_load), .memDataOut(memDataOut),
    .memDataOe(memDataOe), .memDataIn(memDataIn));
  ntsp_sram_model ntsp_sram_model_inst (.clk(clk), .rst(rst), .pipe(pipelinedMode),
    .addr(memAddr), .rwLow(readWriteLow), .beLow(byte_write_enable_low),
    .dOut(memDataOut), .dIn(memDataIn), .expOe(expOe));
  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Sends all rows back to back, then checks every read came home in time.
  task automatic run_rows(input logic mode);
    pipelinedMode <= mode;
    @(posedge clk);
    foreach (Rows[i])
    begin
      if (!Rows[i].wr) expQ.push_back(Rows[i].e);
      reqValid <= 1'b1;
      reqWrite <= Rows[i].wr;
      reqAddr <= {14'h0000, Rows[i].a};
      reqWrData <= Rows[i].d;
      reqByteEn <= Rows[i].be;
      @(posedge clk);
    end
    reqValid <= 1'b0;
    // A dead cycle at every switch would leave reads still pending here.
    repeat (6 + mode) @(posedge clk);
    check(32'(expQ.size()), 32'h0, "pending reads");
  endtask
  // Free-running clock of 50 ns.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Each settled cycle: bus direction, fixed load mode and read data order.
  always @(negedge clk)
  begin
    if (!rst)
    begin
      check(32'(memDataOe), 32'(expOe), "data enable");
      check(32'(burst_advance_or_load), 32'h0, "advance or load");
      check(32'(reqReady), 32'h1, "request ready");
      if (rdValid !== 1'b0 && expQ.size() == 0) check(32'(rdValid), 32'h0, "stray read");
      else if (rdValid !== 1'b0) check(rdData, expQ.pop_front(), "read data");
    end
  end
  // Watchdog well beyond the expected run of some seventy cycles.
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    {rst, pipelinedMode, reqValid, reqWrite} = 4'h8;
    {reqAddr, reqWrData, reqByteEn} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    run_rows(1'b0);
    run_rows(1'b1);
    // Reset in the data cycle of a pipelined write must quiet the bus at once.
    reqValid <= 1'b1;
    reqWrite <= 1'b1;
    reqWrData <= 32'h5a5a5a5a;
    reqByteEn <= 4'hf;
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    expQ.delete();
    check(32'(memDataOe), 32'h0, "reset enable");
    check({27'h0, readWriteLow, byte_write_enable_low}, 32'h1f, "reset controls");
    check(32'(rdValid), 32'h0, "reset read valid");
    @(posedge clk);
    rst <= 1'b0;
    run_rows(1'b0);
    tally_and_finish();
  end
endmodule // testbench
